// [mpsc_ctrl.sv]
// mpsc_ctrl: execution mode, privilege and stack select for the core.
// assumes exception logic and decoder drive synchronous requests, and
// the fetch unit returns the reset-vector word with vec_valid.
//
// Overview of operation
// - leave reset in thread mode
// - handler mode until all exceptions done
// - unprivileged: no state change, limited moves
// - unprivileged: timer, interrupt, control blocked
// - unprivileged memory follows protection verdict
// - privileged code is never restricted
// - thread privilege comes from control bit
// - handler mode is always privileged
// - only privileged writes change privilege bit
// - supervisor call from thread mode enters privileged handler
// - stacks are full descending
// - push decrements pointer before writing
// - two independent stack pointers
// - thread stack chosen by control bit
// - handler mode always uses main stack
// - control bit 1 selects process stack
// - main pointer loaded from vector word
// - nine-bit active exception number
`timescale 1ns/10ps
`default_nettype none
module mpsc_ctrl
  import mpsc_pkg::*;
(
  input  wire logic          clk,          // core clock, 20 MHz
  input  wire logic          reset,        // sync reset, active high
  input  wire logic          vec_valid,    // reset vector word arrived
  input  wire logic   [31:0] vec_data,     // reset vector word
  input  wire mpsc_exc_type  exc,          // exception events
  input  wire mpsc_req_type  req,          // decoder check request
  input  wire mpsc_stk_type  stk,          // stack request
  output logic               vec_req,      // fetch word at vector addr
  output logic        [31:0] vec_addr,     // address to fetch
  output logic               handler_mode, // 1 in handler mode
  output logic               privileged,   // effective privilege
  output logic               use_process,  // active stack is process
  output logic        [8:0]  active_exception_number, // 0 in thread
  output logic        [1:0]  control_bits, // stored control register
  output mpsc_resp_type      resp,         // verdict, one cycle after
  output logic        [31:0] main_sp,      // main stack pointer
  output logic        [31:0] proc_sp,      // process stack pointer
  output logic        [31:0] active_sp,    // active stack pointer
  output logic        [31:0] push_addr     // where next push writes
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_THREAD,
    ST_HANDLER
  } mpsc_mode_type;

  typedef struct packed {
    mpsc_mode_type mode;
    logic          hmode;
    logic [8:0]    exc_num;
    logic [1:0]    ctrl;
    logic          vec_req;
    mpsc_resp_type resp;
    logic          priv;
    logic          proc;
    logic [31:0]   act_sp;
    logic [31:0]   push_a;
  } mpsc_state_type;

  mpsc_state_type st_r;
  mpsc_state_type st_nxt;

  logic        priv_now;
  logic        proc_now;
  logic        allow;
  logic        ctrl_wr_ok;
  logic        load_main;
  logic [31:0] msp_w;
  logic [31:0] psp_w;
  logic [31:0] push_w;
  logic        svc_take;

  ////////////////////////////////////////////////////////////////////
  // combinational view of the current mode

  // handler mode overrides the control bits for privilege and stack
  assign priv_now = (st_r.mode == ST_HANDLER)
                    || !st_r.ctrl[CTRL_PRIV_BIT];
  assign proc_now = (st_r.mode == ST_THREAD)
                    && st_r.ctrl[CTRL_SPSEL_BIT];
  assign load_main = (st_r.mode == ST_BOOT) && vec_valid;
  assign svc_take  = req.valid && req.supervisor_call_instr;

  mpsc_access_check u_check
  (
    .privileged (priv_now),
    .req        (req),
    .allow      (allow),
    .ctrl_wr_ok (ctrl_wr_ok)
  );

  mpsc_stack_regs u_stack
  (
    .clk       (clk),
    .reset     (reset),
    .load_main (load_main),
    .load_val  (vec_data),
    .sel_proc  (proc_now),
    .stk       ((st_r.mode == ST_BOOT) ? '0 : stk),
    .main_sp   (msp_w),
    .proc_sp   (psp_w),
    .push_addr (push_w)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.vec_req = 1'b0;
    st_nxt.resp    = '0;

    case (st_r.mode)
      // hold off execution until the main pointer is loaded
      ST_BOOT:
      begin
        st_nxt.vec_req = !vec_valid;
        if (vec_valid)
          st_nxt.mode = ST_THREAD;
      end
      ST_THREAD:
      begin
        if (exc.entry)
        begin
          st_nxt.mode    = ST_HANDLER;
          st_nxt.exc_num = exc.entry_num;
        end
        else if (svc_take)
        begin
          st_nxt.mode    = ST_HANDLER;
          st_nxt.exc_num = EXC_SVCALL;
        end
      end
      ST_HANDLER:
      begin
        if (exc.entry)
          st_nxt.exc_num = exc.entry_num;
        else if (exc.ret)
        begin
          // a return to zero with work still pending stays in handler
          if (exc.all_done && exc.ret_num == EXC_THREAD)
          begin
            st_nxt.mode    = ST_THREAD;
            st_nxt.exc_num = EXC_THREAD;
          end
          else if (exc.ret_num != EXC_THREAD)
            st_nxt.exc_num = exc.ret_num;
        end
      end
      default: st_nxt.mode = ST_BOOT;
    endcase

    // control writes; unprivileged may only touch stack select
    if (st_r.mode != ST_BOOT && req.valid
        && req.res == RES_SPECIAL_REG && req.sreg_write
        && req.sreg_ctrl)
    begin
      if (ctrl_wr_ok)
        st_nxt.ctrl = req.sreg_data & CTRL_WMASK;
      else
        st_nxt.ctrl[CTRL_SPSEL_BIT] =
          req.sreg_data[CTRL_SPSEL_BIT];
    end

    if (req.valid && st_r.mode != ST_BOOT)
    begin
      st_nxt.resp.valid    = 1'b1;
      st_nxt.resp.allow    = allow;
      st_nxt.resp.fault    = !allow;
      // an exception entry in the same cycle wins over the call
      st_nxt.resp.svc_take = svc_take && st_r.mode == ST_THREAD
                             && !exc.entry;
    end

    // registered copies of the stack view; one cycle behind pointers
    st_nxt.hmode  = (st_nxt.mode == ST_HANDLER);
    st_nxt.priv   = (st_nxt.mode == ST_HANDLER)
                    || !st_nxt.ctrl[CTRL_PRIV_BIT];
    st_nxt.proc   = (st_nxt.mode == ST_THREAD)
                    && st_nxt.ctrl[CTRL_SPSEL_BIT];
    st_nxt.act_sp = proc_now ? psp_w : msp_w;
    st_nxt.push_a = push_w;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r         <= '0;
      st_r.mode    <= ST_BOOT;
      st_r.ctrl    <= CTRL_RESET;
      st_r.exc_num <= EXC_THREAD;
      st_r.vec_req <= 1'b1;
      st_r.priv    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign vec_req                 = st_r.vec_req;
  assign vec_addr                = VECTOR_ADDR;
  assign handler_mode            = st_r.hmode;
  assign privileged              = st_r.priv;
  assign use_process             = st_r.proc;
  assign active_exception_number = st_r.exc_num;
  assign control_bits            = st_r.ctrl;
  assign resp                    = st_r.resp;
  assign main_sp                 = msp_w;
  assign proc_sp                 = psp_w;
  assign active_sp               = st_r.act_sp;
  assign push_addr               = st_r.push_a;

endmodule
`default_nettype wire

// [mpsc_pkg.sv]
// mpsc_pkg: shared constants and carrier types for the mode, privilege
// and stack pointer controller.
// assumes a 32-bit core datapath and a 9-bit exception number.
package mpsc_pkg;

  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned EXC_W         = 9;
  localparam logic [31:0] SP_STEP       = 32'h0000_0004;
  localparam logic [31:0] VECTOR_ADDR   = 32'h0000_0000;
  localparam int unsigned CTRL_PRIV_BIT = 0;
  localparam int unsigned CTRL_SPSEL_BIT = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam logic [8:0]  EXC_THREAD    = 9'h000;
  localparam logic [8:0]  EXC_SVCALL    = 9'h00B;
  localparam logic [1:0]  CTRL_WMASK    = 2'h3;

  // resource classes an access or instruction may touch
  typedef enum logic [2:0] {
    RES_NONE,
    RES_MEMORY,
    RES_SYS_TICK,
    RES_INT_CTRL,
    RES_SYS_CTRL,
    RES_SPECIAL_REG,
    RES_PROC_STATE
  } mpsc_res_type;

  // stack operation requested by the datapath
  typedef enum logic [1:0] {
    SOP_NONE,
    SOP_PUSH,
    SOP_POP,
    SOP_WRITE
  } mpsc_sop_type;

  // exception sequencing events from the exception logic
  typedef struct packed {
    logic       entry;       // handler entered
    logic [8:0] entry_num;   // number of handler entered
    logic       ret;         // exception return
    logic [8:0] ret_num;     // number to resume (0 = back to thread)
    logic       all_done;    // nothing pending or active remains
  } mpsc_exc_type;

  // decoded instruction/access check request
  typedef struct packed {
    logic         valid;
    mpsc_res_type res;
    logic         region_ok; // protection verdict for memory accesses
    logic         sreg_write; // special-register move is a write
    logic         sreg_ctrl; // special-register move targets control
    logic [1:0]   sreg_data; // data for control write
    logic         supervisor_call_instr;       // supervisor call instruction
  } mpsc_req_type;

  // stack request
  typedef struct packed {
    mpsc_sop_type op;
    logic         use_main;  // explicit write target: 1 main, 0 process
    logic [31:0]  wdata;     // explicit write value
  } mpsc_stk_type;

  // verdict returned to the decoder
  typedef struct packed {
    logic valid;
    logic allow;
    logic fault;
    logic svc_take;
  } mpsc_resp_type;

  function automatic logic [31:0] sp_pre_dec(input logic [31:0] sp);
    sp_pre_dec = sp - SP_STEP;
  endfunction

  function automatic logic [31:0] sp_post_inc(input logic [31:0] sp);
    sp_post_inc = sp + SP_STEP;
  endfunction

endpackage

// [mpsc_access_check.sv]
// mpsc_access_check: combinational verdict on one instruction or access
// against the current privilege.
// assumes the request is decoded and stable within the cycle.
`timescale 1ns/10ps
`default_nettype none
module mpsc_access_check
  import mpsc_pkg::*;
(
  input  wire logic    privileged,  // effective privilege
  input  wire mpsc_req_type req,    // decoded request
  output logic         allow,       // request may proceed
  output logic         ctrl_wr_ok   // control write takes effect
);

  always_comb
  begin
    allow      = 1'b1;
    ctrl_wr_ok = 1'b0;
    if (privileged)
    begin
      allow      = 1'b1;
      ctrl_wr_ok = req.valid && req.res == RES_SPECIAL_REG
                   && req.sreg_write && req.sreg_ctrl;
    end
    else
    begin
      case (req.res)
        RES_PROC_STATE:  allow = 1'b0;
        RES_SYS_TICK,
        RES_INT_CTRL,
        RES_SYS_CTRL:    allow = 1'b0;
        RES_MEMORY:      allow = req.region_ok;
        // only the stack select may be changed unprivileged; the
        // privilege bit stays put
        RES_SPECIAL_REG: allow = 1'b1;
        default:         allow = 1'b1;
      endcase
    end
  end

endmodule
`default_nettype wire

// [mpsc_stack_regs.sv]
// mpsc_stack_regs: two independent full-descending stack pointers.
// assumes the caller selects which pointer a push or pop uses.
`timescale 1ns/10ps
`default_nettype none
module mpsc_stack_regs
  import mpsc_pkg::*;
(
  input  wire logic         clk,        // core clock
  input  wire logic         reset,      // sync reset, active high
  input  wire logic         load_main,  // reset-vector load strobe
  input  wire logic [31:0]  load_val,   // initial main pointer
  input  wire logic         sel_proc,   // active pointer is process
  input  wire mpsc_stk_type stk,        // stack request
  output logic      [31:0]  main_sp,    // main pointer
  output logic      [31:0]  proc_sp,    // process pointer
  output logic      [31:0]  push_addr   // address for this push
);

  typedef struct packed {
    logic [31:0] main_stack_pointer;
    logic [31:0] process_stack_pointer;
  } mpsc_sp_type;

  mpsc_sp_type st_r;
  mpsc_sp_type st_nxt;
  logic [31:0] active;

  assign active    = sel_proc ? st_r.process_stack_pointer : st_r.main_stack_pointer;
  assign push_addr = sp_pre_dec(active);
  assign main_sp   = st_r.main_stack_pointer;
  assign proc_sp   = st_r.process_stack_pointer;

  always_comb
  begin
    st_nxt = st_r;
    if (load_main)
      st_nxt.main_stack_pointer = load_val;
    else
    begin
      case (stk.op)
        // decrement first, then the item lands at the new top
        SOP_PUSH:
        begin
          if (sel_proc)
            st_nxt.process_stack_pointer = sp_pre_dec(st_r.process_stack_pointer);
          else
            st_nxt.main_stack_pointer = sp_pre_dec(st_r.main_stack_pointer);
        end
        SOP_POP:
        begin
          if (sel_proc)
            st_nxt.process_stack_pointer = sp_post_inc(st_r.process_stack_pointer);
          else
            st_nxt.main_stack_pointer = sp_post_inc(st_r.main_stack_pointer);
        end
        SOP_WRITE:
        begin
          if (stk.use_main)
            st_nxt.main_stack_pointer = stk.wdata;
          else
            st_nxt.process_stack_pointer = stk.wdata;
        end
        default: st_nxt = st_r;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule
`default_nettype wire

// [mpsc_checker.sv]
// mpsc_checker: timing relations between mode, privilege and stack outputs.
// assumes it is bound to mpsc_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mpsc_checker
  import mpsc_pkg::*;
(
  input wire logic          clk,          // core clock
  input wire logic          reset,        // sync reset
  input wire logic          vec_valid,    // vector strobe
  input wire logic   [31:0] vec_data,     // vector word
  input wire mpsc_exc_type  exc,          // exception events
  input wire mpsc_req_type  req,          // check request
  input wire mpsc_stk_type  stk,          // stack request
  input wire logic          vec_req,      // boot fetch pending
  input wire logic          handler_mode, // handler mode
  input wire logic          privileged,   // effective privilege
  input wire logic          use_process,  // process stack active
  input wire logic   [8:0]  active_exception_number, // exception
  input wire logic   [1:0]  control_bits, // control register
  input wire mpsc_resp_type resp,         // verdict
  input wire logic   [31:0] main_sp,      // main pointer
  input wire logic   [31:0] proc_sp       // process pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic quiet;
  // no event that could move mode or stack select this cycle
  assign quiet = !vec_req && !exc.entry && !exc.ret && !req.valid;
  ////////////////////////////////////////////////////////////////////////
  boot_state_a:
    assert property ($fell(reset) |-> vec_req && privileged && !handler_mode
      && control_bits == CTRL_RESET) else $error("bad state after reset");
  vec_load_a:
    assert property (vec_req && vec_valid |=> !vec_req && !handler_mode
      && main_sp == $past(vec_data)) else $error("vector load wrong");
  handler_priv_a:
    assert property (handler_mode |-> privileged && !use_process)
      else $error("handler not privileged on main stack");
  thread_sel_a:
    assert property (!handler_mode && !vec_req |-> privileged ==
      !control_bits[0] && use_process == control_bits[1])
      else $error("thread select differs from control");
  svc_enter_a:
    assert property (req.valid && req.supervisor_call_instr && !handler_mode && !vec_req
      && !exc.entry |=> handler_mode && resp.svc_take
      && active_exception_number == EXC_SVCALL) else $error("svc not taken");
  priv_allow_a:
    assert property (req.valid && privileged && !req.supervisor_call_instr && !vec_req |=>
      resp.valid && resp.allow && !resp.fault) else $error("priv refused");
  unpriv_block_a:
    assert property (req.valid && !privileged && !exc.entry && req.res inside
      {RES_SYS_TICK, RES_INT_CTRL, RES_SYS_CTRL, RES_PROC_STATE} |=>
      resp.fault && !resp.allow) else $error("blocked access allowed");
  mem_prot_a:
    assert property (req.valid && !privileged && !exc.entry
      && req.res == RES_MEMORY |=> resp.allow == $past(req.region_ok))
      else $error("memory verdict wrong");
  priv_keep_a:
    assert property (req.valid && req.sreg_write && req.sreg_ctrl
      && !privileged && !exc.entry && !exc.ret |=> !privileged)
      else $error("unprivileged write raised privilege");
  push_main_a:
    assert property (stk.op == SOP_PUSH && !use_process && quiet |=>
      main_sp == $past(main_sp) - SP_STEP && $stable(proc_sp))
      else $error("main push wrong");
  ret_thread_a:
    assert property (handler_mode && exc.ret && !exc.entry
      && exc.ret_num == EXC_THREAD |=> handler_mode == !$past(exc.all_done))
      else $error("return mode wrong");
endmodule
bind mpsc_ctrl mpsc_checker i_chk (.clk, .reset, .vec_valid, .vec_data,
  .exc, .req, .stk, .vec_req, .handler_mode, .privileged, .use_process,
  .active_exception_number, .control_bits, .resp, .main_sp, .proc_sp);
`default_nettype wire

// [mpsc_vec_model.sv]
// mpsc_vec_model: fetch side answering the boot vector request.
// assumes one request per reset; latency set by wait_cyc.
`timescale 1ns/10ps
`default_nettype none
module mpsc_vec_model
  import mpsc_pkg::*;
#(
  parameter logic [31:0] WORD = 32'h2000_1000 // initial main pointer
)
(
  input  wire logic        clk,       // core clock
  input  wire logic        reset,     // sync reset
  input  wire logic        vec_req,   // fetch request
  input  wire logic [31:0] vec_addr,  // fetch address
  input  wire logic [3:0]  wait_cyc,  // answer latency
  output logic             vec_valid, // word strobe
  output logic      [31:0] vec_data   // word
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk)
  begin
    if (reset || !vec_req)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hF)
      cnt_r <= cnt_r + 4'h1;
  end
  // only a fetch from the vector address is answered
  assign vec_valid = vec_req && cnt_r == wait_cyc && vec_addr == VECTOR_ADDR;
  // bus follows the wait count while a fetch is pending, so a stale word cannot pass
  assign vec_data = vec_valid ? WORD : ~WORD ^ {28'h0, cnt_r};
endmodule
`default_nettype wire

// [mode_privilege_stack_ctrl_tb.sv]
// mode_privilege_stack_ctrl_tb: self-checking bench for mpsc_ctrl.
// assumes mpsc_vec_model answers the boot fetch.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin err_count++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module mode_privilege_stack_ctrl_tb
  import mpsc_pkg::*;
;
  localparam logic [31:0] VWORD = 32'h2000_1000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic vec_valid, vec_req, handler_mode, privileged, use_process;
  logic [31:0] vec_data, vec_addr, main_sp, proc_sp, active_sp, push_addr;
  logic [31:0] exp_main, exp_proc, v;
  logic [8:0] num, enum_v;
  logic [1:0] control_bits;
  logic [15:0] lfsr_r;
  mpsc_exc_type exc, e;
  mpsc_req_type req, r;
  mpsc_stk_type stk;
  mpsc_resp_type resp, rsp;
  int err_count, total_checks, cyc;
  mpsc_ctrl i_dut (.clk(clk), .reset(reset), .vec_valid(vec_valid),
    .vec_data(vec_data), .exc(exc), .req(req), .stk(stk),
    .vec_req(vec_req), .vec_addr(vec_addr), .handler_mode(handler_mode),
    .privileged(privileged), .use_process(use_process),
    .active_exception_number(num), .control_bits(control_bits),
    .resp(resp), .main_sp(main_sp), .proc_sp(proc_sp),
    .active_sp(active_sp), .push_addr(push_addr));
  mpsc_vec_model #(.WORD(VWORD)) i_vec (.clk(clk), .reset(reset),
    .vec_req(vec_req), .vec_addr(vec_addr), .wait_cyc(4'h3),
    .vec_valid(vec_valid), .vec_data(vec_data));
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= 3000)
    begin
      err_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // unprivileged code keeps special-register moves and protected memory
  function automatic logic exp_allow(input logic priv,
                                     input mpsc_res_type rs,
                                     input logic ok);
    case (rs)
      RES_MEMORY:      exp_allow = priv || ok;
      RES_SPECIAL_REG,
      RES_NONE:        exp_allow = 1'b1;
      default:         exp_allow = priv;
    endcase
  endfunction
  task automatic rnd();
    lfsr_r = lfsr(lfsr_r);
    v[31:16] = lfsr_r;
    lfsr_r = lfsr(lfsr_r);
    v[15:0] = lfsr_r;
  endtask
  task step();
    @(posedge clk);
    #5;
  endtask
  // an idle cycle follows each request so no input is set twice at once
  task send(input mpsc_req_type rq, input mpsc_stk_type sk,
            input mpsc_exc_type ex);
    req = rq;
    stk = sk;
    exc = ex;
    step();
    rsp = resp;
    req = '0;
    stk = '0;
    exc = '0;
    step();
  endtask
  task ctrl_wr(input logic [1:0] d);
    r = '0;
    r.valid = 1'b1;
    r.res = RES_SPECIAL_REG;
    r.sreg_write = 1'b1;
    r.sreg_ctrl = 1'b1;
    r.sreg_data = d;
    send(r, '0, '0);
  endtask
  task push_chk(input logic proc);
    if (proc)
      exp_proc -= SP_STEP;
    else
      exp_main -= SP_STEP;
    send('0, '{SOP_PUSH, 1'b0, 32'h0}, '0);
    `CHK(main_sp, exp_main)
    `CHK(proc_sp, exp_proc)
    `CHK(active_sp, proc ? exp_proc : exp_main)
    `CHK(push_addr, (proc ? exp_proc : exp_main) - SP_STEP)
  endtask
  task pop_chk(input logic proc);
    if (proc)
      exp_proc += SP_STEP;
    else
      exp_main += SP_STEP;
    send('0, '{SOP_POP, 1'b0, 32'h0}, '0);
    `CHK(main_sp, exp_main)
    `CHK(proc_sp, exp_proc)
  endtask
  task sweep(input logic priv);
    logic a;
    for (int i = 1; i < 7; i++)
    begin
      rnd();
      r = '0;
      r.valid = 1'b1;
      r.res = mpsc_res_type'(i);
      r.region_ok = v[0];
      a = exp_allow(priv, r.res, v[0]);
      send(r, '0, '0);
      `CHK(rsp.allow, a)
      if (i != 1 || priv) `CHK(rsp.fault, ~a)
    end
  endtask
  task svc_call();
    r = '0;
    r.valid = 1'b1;
    r.supervisor_call_instr = 1'b1;
    send(r, '0, '0);
    `CHK(rsp.svc_take, 1'b1)
    `CHK(handler_mode, 1'b1)
    `CHK(privileged, 1'b1)
    `CHK(num, EXC_SVCALL)
  endtask
  task ret_all(input logic done);
    e = '0;
    e.ret = 1'b1;
    e.all_done = done;
    send('0, '0, e);
    `CHK(handler_mode, ~done)
  endtask
  task close_out();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {req, stk, exc} = '0;
    lfsr_r = 16'hAF2D;
    {err_count, total_checks, cyc} = '0;
    repeat (5) @(posedge clk);
    #5 reset = 1'b0;
    `CHK(vec_req, 1'b1)
    for (int k = 0; k < 20 && vec_req !== 1'b0; k++)
      step();
    `CHK(main_sp, VWORD)
    `CHK(handler_mode, 1'b0)
    `CHK(num, EXC_THREAD)
    `CHK(use_process, 1'b0)
    `CHK(vec_addr, VECTOR_ADDR)
    exp_main = VWORD;
    rnd();
    exp_proc = {v[31:2], 2'h0};
    send('0, '{SOP_WRITE, 1'b0, exp_proc}, '0);
    `CHK(proc_sp, exp_proc)
    rnd();
    exp_main = {v[31:2], 2'h0};
    send('0, '{SOP_WRITE, 1'b1, exp_main}, '0);
    `CHK(main_sp, exp_main)
    `CHK(proc_sp, exp_proc)
    sweep(1'b1);
    repeat (3) push_chk(1'b0);
    pop_chk(1'b0);
    ctrl_wr(2'h2);
    `CHK(use_process, 1'b1)
    `CHK(privileged, 1'b1)
    repeat (3) push_chk(1'b1);
    pop_chk(1'b1);
    svc_call();
    `CHK(use_process, 1'b0)
    push_chk(1'b0);
    ret_all(1'b0);
    ret_all(1'b1);
    `CHK(use_process, 1'b1)
    ctrl_wr(2'h3);
    `CHK(privileged, 1'b0)
    sweep(1'b0);
    ctrl_wr(2'h0);
    `CHK(control_bits, 2'h1)
    `CHK(use_process, 1'b0)
    rnd();
    enum_v = {1'b0, v[7:0]} | 9'h010;
    e = '0;
    e.entry = 1'b1;
    e.entry_num = enum_v;
    send('0, '0, e);
    `CHK(privileged, 1'b1)
    `CHK(num, enum_v)
    sweep(1'b1);
    ret_all(1'b1);
    `CHK(privileged, 1'b0)
    svc_call();
    close_out();
  end
endmodule
`default_nettype wire
